/* common/vsdm_pkg.sv */
// Constants for the velocity select and dual mode block.
// Assumes a 10 MHz system clock and an APB register bus.
package vsdm_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] RAMP_OFS  = 8'h04;
  localparam logic [7:0] ROT12_OFS = 8'h08;
  localparam logic [7:0] ROT3_OFS  = 8'h0c;
  localparam logic [7:0] LIN12_OFS = 8'h10;
  localparam logic [7:0] LIN3_OFS  = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h18;
  // Field positions
  localparam int METHOD_LSB = 0;
  localparam int USAGE_LSB  = 4;
  localparam int LINEAR_BIT = 8;
  localparam int APPLY_BIT  = 9;
  localparam int HI_LSB     = 16;
  localparam int MODE_LSB   = 4;
  localparam int SWITCH_BIT = 7;
  // Reset values
  localparam logic [3:0]  METHOD_RST = 4'h3;
  localparam logic [3:0]  USAGE_RST  = 4'h0;
  localparam logic [15:0] ROT_V1_RST = 16'h0064;
  localparam logic [15:0] ROT_V2_RST = 16'h00c8;
  localparam logic [15:0] ROT_V3_RST = 16'h012c;
  localparam logic [15:0] LIN_V1_RST = 16'h000a;
  localparam logic [15:0] LIN_V2_RST = 16'h0014;
  localparam logic [15:0] LIN_V3_RST = 16'h001e;
  localparam logic [15:0] RAMP_RST   = 16'h0000;
  // Control method codes
  localparam logic [3:0] METH_VEL   = 4'h0;
  localparam logic [3:0] METH_POS   = 4'h1;
  localparam logic [3:0] METH_TRQ   = 4'h2;
  localparam logic [3:0] METH_IVEL  = 4'h3;
  localparam logic [3:0] METH_IV_P  = 4'h4;
  localparam logic [3:0] METH_IV_V  = 4'h5;
  localparam logic [3:0] METH_IV_T  = 4'h6;
  localparam logic [3:0] METH_P_V   = 4'h7;
  localparam logic [3:0] METH_P_T   = 4'h8;
  localparam logic [3:0] METH_T_V   = 4'h9;
  localparam logic [3:0] METH_IPOS  = 4'ha;
  localparam logic [3:0] METH_IP_P  = 4'hb;
  localparam logic [3:0] METH_IP_V  = 4'hc;
  localparam logic [3:0] METH_IP_T  = 4'hd;
  localparam logic [3:0] METH_IV_IP = 4'he;
  localparam logic [3:0] USAGE_SEL  = 4'h0;
  // Timing: ramp times count in ms over a full scale of velocity units
  localparam int CLK_PERIOD_NS  = 100;
  localparam int MS_NS          = 1000000;
  localparam int VEL_FULL_SCALE = 10000;
  typedef enum logic [2:0] {MODE_POS, MODE_VEL, MODE_TRQ, MODE_IPOS, MODE_IVEL} vsdm_mode_t;
endpackage

/* rtl/vsdm_velocity_select.sv */
// Set-point and control mode selection for a servo drive.
// Assumes digital inputs from an external controller on pins and APB set-up.
// Notes on behaviour
// - Both select inputs off in internal velocity mode: zero velocity, stopped.
// - A off, B on: run at set velocity 1, rotary or linear.
// - A and B on: run at set velocity 2, rotary or linear.
// - A on, B off: run at set velocity 3, rotary or linear.
// - Direction input off gives forward, on gives reverse.
// - Velocity changes ramp with acceleration or deceleration time.
// - Five single modes plus dual modes pairing two of them.
// - Mode switch off selects first mode, on selects second.
// - Codes 4 to 9 decode to their listed mode pairs.
// - Codes B to E decode to their listed mode pairs.
// - Codes 4,5,6,E with usage 0: select inputs force internal velocity.
// - Entry into internal velocity mode accepted at any time.
// - Select input changes act within 2 ms.
// - Leaving internal velocity for position: decelerate to stop first.
// - Position pulses ignored until position mode is reached.
// - Positioning complete output only once in position mode.
// - New control method takes effect only at next power-up; here at an APB restart request, which applies the method pending before it; reset loads code 3.
// - Ramp times in 1 ms steps, 0 to 65535, effective at once.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module vsdm_velocity_select
  import vsdm_pkg::*;
#(
  parameter int CYC_PER_MS = MS_NS / CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  // APB slave
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Controller pins
  input  wire logic               velocitySelectA,
  input  wire logic               velocitySelectB,
  input  wire logic               directionSelect,
  input  wire logic               modeSwitch,
  input  wire logic               posPulseIn,
  // Position loop
  input  wire logic               posSettled,
  // Drive outputs
  output vsdm_mode_t              activeMode,
  output logic signed [15:0]      velCommand,
  output logic                    posPulseOut,
  output logic                    inPositionOutput
);
  localparam int TICK_RAW = CYC_PER_MS / VEL_FULL_SCALE;
  localparam logic [15:0] TICK_LAST = 16'((TICK_RAW < 1) ? 0 : TICK_RAW - 1);

  // Pin synchronisers
  logic [4:0] pinMeta_reg;
  logic [4:0] pinSync_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinMeta_reg <= 5'h00;
      pinSync_reg <= 5'h00;
    end else begin
      pinMeta_reg <= {posPulseIn, modeSwitch, directionSelect, velocitySelectB, velocitySelectA};
      pinSync_reg <= pinMeta_reg;
    end
  end
  wire selA   = pinSync_reg[0];
  wire selB   = pinSync_reg[1];
  wire selDir = pinSync_reg[2];
  wire selC   = pinSync_reg[3];
  wire selP   = pinSync_reg[4];

  // APB decode
  wire wrEn   = psel & penable & pwrite;
  wire hitCtl = paddr == CTRL_OFS;
  wire hitRmp = paddr == RAMP_OFS;
  wire hitR12 = paddr == ROT12_OFS;
  wire hitR3  = paddr == ROT3_OFS;
  wire hitL12 = paddr == LIN12_OFS;
  wire hitL3  = paddr == LIN3_OFS;
  wire hitSt  = paddr == STAT_OFS;
  wire hitAny = hitCtl | hitRmp | hitR12 | hitR3 | hitL12 | hitL3 | hitSt;
  wire applyReq = wrEn & hitCtl & pwdata[APPLY_BIT];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  logic [3:0]  methodPend_reg, usagePend_reg, activeMethod_reg, activeUsage_reg;
  logic        linear_reg;
  logic [15:0] rampUp_reg, rampDown_reg;
  logic [15:0] rotV1_reg, rotV2_reg, rotV3_reg, linV1_reg, linV2_reg, linV3_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      methodPend_reg <= METHOD_RST;
      usagePend_reg  <= USAGE_RST;
      linear_reg     <= 1'b0;
      rampUp_reg     <= RAMP_RST;
      rampDown_reg   <= RAMP_RST;
      rotV1_reg      <= ROT_V1_RST;
      rotV2_reg      <= ROT_V2_RST;
      rotV3_reg      <= ROT_V3_RST;
      linV1_reg      <= LIN_V1_RST;
      linV2_reg      <= LIN_V2_RST;
      linV3_reg      <= LIN_V3_RST;
    end else if (wrEn) begin
      if (hitCtl) begin
        methodPend_reg <= pwdata[METHOD_LSB +: 4];
        usagePend_reg  <= pwdata[USAGE_LSB +: 4];
        linear_reg     <= pwdata[LINEAR_BIT];
      end
      if (hitRmp) begin
        rampUp_reg   <= pwdata[15:0];
        rampDown_reg <= pwdata[HI_LSB +: 16];
      end
      if (hitR12) begin
        rotV1_reg <= pwdata[15:0];
        rotV2_reg <= pwdata[HI_LSB +: 16];
      end
      if (hitR3) rotV3_reg <= pwdata[15:0];
      if (hitL12) begin
        linV1_reg <= pwdata[15:0];
        linV2_reg <= pwdata[HI_LSB +: 16];
      end
      if (hitL3) linV3_reg <= pwdata[15:0];
    end
  end

  // Method in force changes only at reset or at a restart request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      activeMethod_reg <= METHOD_RST;
      activeUsage_reg  <= USAGE_RST;
    end else if (applyReq) begin
      activeMethod_reg <= methodPend_reg;
      activeUsage_reg  <= usagePend_reg;
    end
  end

  // Method decode
  vsdm_mode_t firstMode, secondMode;
  logic       isDual, ivPairMethod;
  always_comb begin
    firstMode    = MODE_VEL;
    secondMode   = MODE_VEL;
    isDual       = 1'b1;
    ivPairMethod = 1'b0;
    unique case (activeMethod_reg)
      METH_VEL:   isDual = 1'b0;
      METH_POS:   begin firstMode = MODE_POS;  isDual = 1'b0; end
      METH_TRQ:   begin firstMode = MODE_TRQ;  isDual = 1'b0; end
      METH_IVEL:  begin firstMode = MODE_IVEL; isDual = 1'b0; end
      METH_IPOS:  begin firstMode = MODE_IPOS; isDual = 1'b0; end
      METH_IV_P:  begin firstMode = MODE_IVEL; secondMode = MODE_POS; ivPairMethod = 1'b1; end
      METH_IV_V:  begin firstMode = MODE_IVEL; ivPairMethod = 1'b1; end
      METH_IV_T:  begin firstMode = MODE_IVEL; secondMode = MODE_TRQ; ivPairMethod = 1'b1; end
      METH_P_V:   firstMode = MODE_POS;
      METH_P_T:   begin firstMode = MODE_POS; secondMode = MODE_TRQ; end
      METH_T_V:   firstMode = MODE_TRQ;
      METH_IP_P:  begin firstMode = MODE_IPOS; secondMode = MODE_POS; end
      METH_IP_V:  firstMode = MODE_IPOS;
      METH_IP_T:  begin firstMode = MODE_IPOS; secondMode = MODE_TRQ; end
      METH_IV_IP: begin firstMode = MODE_IVEL; secondMode = MODE_IPOS; ivPairMethod = 1'b1; end
      default:    isDual = 1'b0;
    endcase
  end

  // Target mode from the switch and select inputs
  wire ivForce = ivPairMethod & (activeUsage_reg == USAGE_SEL);
  wire selAny  = selA | selB;
  vsdm_mode_t targetMode;
  assign targetMode = ivForce ? (selAny ? MODE_IVEL : secondMode) :
                      isDual ? (selC ? secondMode : firstMode) : firstMode;

  // Set velocity selection
  wire [15:0] set1 = linear_reg ? linV1_reg : rotV1_reg;
  wire [15:0] set2 = linear_reg ? linV2_reg : rotV2_reg;
  wire [15:0] set3 = linear_reg ? linV3_reg : rotV3_reg;
  wire [15:0] selMag = !selAny ? 16'h0000 :
                       (selA & selB) ? set2 : selA ? set3 : set1;
  wire signed [15:0] magS = $signed({1'b0, selMag[14:0]});
  vsdm_mode_t activeMode_reg;
  wire ivRun = (activeMode_reg == MODE_IVEL) & (targetMode == MODE_IVEL);
  wire signed [15:0] targetVel = !ivRun ? 16'sh0000 : selDir ? -magS : magS;

  // Ramp generator
  logic signed [15:0] velCommand_reg;
  logic [15:0]        stepCnt_reg, tickCnt_reg;
  wire velPos   = velCommand_reg > 16'sh0000;
  wire velNeg   = velCommand_reg < 16'sh0000;
  wire decel    = (velPos & (targetVel < velCommand_reg)) |
                  (velNeg & (targetVel > velCommand_reg));
  wire [15:0] rampTime = decel ? rampDown_reg : rampUp_reg;
  wire tick     = tickCnt_reg == TICK_LAST;
  wire atTarget = velCommand_reg == targetVel;
  wire jump     = rampTime == 16'h0000;
  wire stepDue  = tick & (({1'b0, stepCnt_reg} + 17'h00001) >= {1'b0, rampTime});
  wire signed [15:0] velNext = jump ? targetVel :
                               (!stepDue | atTarget) ? velCommand_reg :
                               (targetVel > velCommand_reg) ? velCommand_reg + 16'sh0001 :
                               velCommand_reg - 16'sh0001;
  wire [15:0] stepNext = (atTarget | jump | stepDue) ? 16'h0000 :
                         tick ? stepCnt_reg + 16'h0001 : stepCnt_reg;

  // Leaving internal velocity waits for standstill; entry is immediate
  wire switching = (activeMode_reg == MODE_IVEL) & (targetMode != MODE_IVEL) &
                   (velCommand_reg != 16'sh0000);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tickCnt_reg    <= 16'h0000;
      stepCnt_reg    <= 16'h0000;
      velCommand_reg <= 16'sh0000;
      activeMode_reg <= MODE_VEL;
    end else begin
      tickCnt_reg    <= tick ? 16'h0000 : tickCnt_reg + 16'h0001;
      stepCnt_reg    <= stepNext;
      velCommand_reg <= velNext;
      if (!switching) activeMode_reg <= targetMode;
    end
  end

  // Pulse gate and completion output only in position mode
  logic posPulse_reg, inPos_reg;
  wire inPosMode = activeMode_reg == MODE_POS;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      posPulse_reg <= 1'b0;
      inPos_reg    <= 1'b0;
    end else begin
      posPulse_reg <= selP & inPosMode;
      inPos_reg    <= posSettled & inPosMode;
    end
  end

  // Read data captured in the setup phase; zero wait states
  wire [31:0] rdMux =
    hitCtl ? {23'h0, linear_reg, usagePend_reg, methodPend_reg} :
    hitRmp ? {rampDown_reg, rampUp_reg} :
    hitR12 ? {rotV2_reg, rotV1_reg} :
    hitR3  ? {16'h0, rotV3_reg} :
    hitL12 ? {linV2_reg, linV1_reg} :
    hitL3  ? {16'h0, linV3_reg} :
    hitSt  ? {velCommand_reg, 8'h0, switching, activeMode_reg, activeMethod_reg} :
    32'h0;
  logic [31:0] prdata_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) prdata_reg <= 32'h0;
    else if (psel & ~penable) prdata_reg <= rdMux;
  end

  assign prdata           = prdata_reg;
  assign activeMode       = activeMode_reg;
  assign velCommand       = velCommand_reg;
  assign posPulseOut      = posPulse_reg;
  assign inPositionOutput = inPos_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_stop_zero: assert property (
    (ivRun && !selA && !selB) |-> targetVel == 16'sh0000)
    else $error("stop select did not give zero velocity");
  chk_vel_one: assert property (
    (ivRun && !selA && selB && !selDir) |-> targetVel == $signed({1'b0, set1[14:0]}))
    else $error("set velocity 1 not selected");
  chk_vel_two: assert property (
    (ivRun && selA && selB && !selDir) |-> targetVel == $signed({1'b0, set2[14:0]}))
    else $error("set velocity 2 not selected");
  chk_vel_three: assert property (
    (ivRun && selA && !selB && !selDir) |-> targetVel == $signed({1'b0, set3[14:0]}))
    else $error("set velocity 3 not selected");
  chk_dir_reverse: assert property (
    (ivRun && selDir) |-> targetVel <= 16'sh0000)
    else $error("reverse direction not applied");
  chk_ramp_step: assert property (
    (!atTarget && !jump) |=> (velCommand_reg - $past(velCommand_reg)) inside {-16'sd1, 16'sd0, 16'sd1})
    else $error("ramp moved by more than one unit");
  chk_ramp_hold: assert property (
    (atTarget && !jump) |=> velCommand_reg == $past(velCommand_reg))
    else $error("ramp moved away from reached target");
  chk_ramp_immediate: assert property (
    (jump && velCommand_reg != targetVel) |=> velCommand_reg == $past(targetVel))
    else $error("zero ramp time did not jump");
  chk_dual_select: assert property (
    (isDual && !ivForce && !switching) |=> activeMode_reg == $past(selC ? secondMode : firstMode))
    else $error("mode switch selected wrong mode");
  chk_decode_pair: assert property (
    (activeMethod_reg == METH_T_V) |-> (firstMode == MODE_TRQ && secondMode == MODE_VEL))
    else $error("torque velocity pair misdecoded");
  chk_decode_ipair: assert property (
    (activeMethod_reg == METH_IV_IP) |-> (firstMode == MODE_IVEL && secondMode == MODE_IPOS))
    else $error("internal pair misdecoded");
  chk_force_ivel: assert property (
    (ivForce && selAny) |=> activeMode_reg == MODE_IVEL)
    else $error("select inputs did not force internal velocity");
  chk_stop_first: assert property (
    (activeMode_reg == MODE_IVEL ##1 activeMode_reg == MODE_POS) |-> $past(velCommand_reg) == 16'sh0000)
    else $error("left internal velocity while moving");
  chk_pulse_gate: assert property (
    posPulse_reg |-> $past(activeMode_reg) == MODE_POS)
    else $error("pulse passed outside position mode");
  chk_in_position_output_gate: assert property (
    inPos_reg |-> $past(activeMode_reg) == MODE_POS)
    else $error("completion output outside position mode");
  chk_method_hold: assert property (
    !applyReq |=> $stable(activeMethod_reg))
    else $error("control method changed without restart");
  chk_reverse_zero: assert property (
    (velPos && targetVel < 16'sh0000 && !jump) |=> velCommand_reg >= 16'sh0000)
    else $error("reversal skipped zero");

  cov_stop_switch: cover property (switching ##[1:1000] (activeMode_reg == MODE_POS));
  cov_pulse: cover property (posPulse_reg);
  cov_reverse: cover property (velPos ##[1:1000] velNeg);
  cov_force: cover property (ivForce && selAny && activeMode_reg != MODE_IVEL);
endmodule // vsdm_velocity_select

/* testbench/vsdm_ctl_model.sv */
// Motion controller model: drives select pins, mode switch and pulses.
// Assumes the drive's clock and its active mode output.
module vsdm_ctl_model
  import vsdm_pkg::*;
#(
  parameter int SETTLE_CYC = 20001
) (
  // Clock and drive state
  input  wire logic clk_sys,
  input  vsdm_mode_t activeMode,
  // Pins to the drive
  output logic      velocitySelectA,
  output logic      velocitySelectB,
  output logic      directionSelect,
  output logic      modeSwitch,
  output logic      posPulseIn
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int swAt = 0;
  initial begin
    {velocitySelectA, velocitySelectB, directionSelect, modeSwitch, posPulseIn} = '0;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic setSel(input logic a, input logic b, input logic d);
    @(posedge clk_sys);
    velocitySelectA <= a;
    velocitySelectB <= b;
    directionSelect <= d;
  endtask
  task automatic setSw(input logic s);
    @(posedge clk_sys);
    modeSwitch <= s;
    swAt = cyc;
  endtask
  // Early is set only by a test that wants a pulse the drive must drop
  task automatic pulse(input bit early);
    if (!early) begin
      while (activeMode !== MODE_POS || cyc - swAt <= SETTLE_CYC) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    posPulseIn <= 1'b1;
    @(posedge clk_sys);
    posPulseIn <= 1'b0;
  endtask
endmodule // vsdm_ctl_model

/* testbench/tb_top.sv */
// Self-checking bench for the velocity select and dual mode block.
// Assumes the controller model and an APB master in this module.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import vsdm_pkg::*;
  logic clk_sys, nrst, psel, penable, pwrite, posSettled;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, vA, vB, dir, sw, pIn, posPulseOut, inPositionOutput;
  vsdm_mode_t activeMode;
  logic signed [15:0] velCommand;
  int err_total = 0;
  int checks = 0;
  int pulseSeen = 0;
  int p0, mag;
  logic [3:0] codes [15] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he,
                             4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
  vsdm_mode_t m1 [15] = '{MODE_IVEL, MODE_IVEL, MODE_IVEL, MODE_POS, MODE_POS, MODE_TRQ,
    MODE_IPOS, MODE_IPOS, MODE_IPOS, MODE_IVEL, MODE_VEL, MODE_POS, MODE_TRQ, MODE_IVEL, MODE_IPOS};
  vsdm_mode_t m2 [15] = '{MODE_POS, MODE_VEL, MODE_TRQ, MODE_VEL, MODE_TRQ, MODE_VEL,
    MODE_POS, MODE_VEL, MODE_TRQ, MODE_IPOS, MODE_VEL, MODE_POS, MODE_TRQ, MODE_IVEL, MODE_IPOS};
  vsdm_velocity_select i_dut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .velocitySelectA(vA), .velocitySelectB(vB), .directionSelect(dir),
    .modeSwitch(sw), .posPulseIn(pIn), .posSettled(posSettled), .activeMode(activeMode),
    .velCommand(velCommand), .posPulseOut(posPulseOut), .inPositionOutput(inPositionOutput));
  vsdm_ctl_model i_ctl (.clk_sys(clk_sys), .activeMode(activeMode), .velocitySelectA(vA),
    .velocitySelectB(vB), .directionSelect(dir), .modeSwitch(sw), .posPulseIn(pIn));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (posPulseOut === 1'b1) pulseSeen++;
  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Read data and error are taken only at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmpVal(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmpSpan(input string n, input int lo, input int hi, input logic signed [15:0] g);
    checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_total++;
      $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  initial begin
    {nrst, psel, penable, pwrite, posSettled} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, CTRL_OFS, '0);
    cmpVal("ctrl", 32'h00000003, rd);
    apb(1'b0, ROT12_OFS, '0);
    cmpVal("rot12", 32'h00c80064, rd);
    apb(1'b0, 8'h20, '0);
    cmpVal("unmapped", 32'h00000001, {rd[30:0], er});
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      i_ctl.setSel(i[2], i[1], i[0]);
      waitc(8);
      mag = (i[2:1] == 2'b00) ? 0 : (i[2:1] == 2'b01) ? 100 : (i[2:1] == 2'b11) ? 200 : 300;
      cmpVal("vel", sx(16'(i[0] ? -mag : mag)), sx(velCommand));
    end
    apb(1'b1, CTRL_OFS, 32'h00000103);
    i_ctl.setSel(1'b1, 1'b1, 1'b0);
    waitc(8);
    cmpVal("linear vel", sx(16'd20), sx(velCommand));
    apb(1'b1, CTRL_OFS, 32'h00000003);
    i_ctl.setSel(1'b0, 1'b0, 1'b0);
    waitc(8);
    $display("test select table done");
    apb(1'b1, RAMP_OFS, 32'h00020001);
    i_ctl.setSel(1'b0, 1'b1, 1'b0);
    waitc(50);
    cmpSpan("vel rising", 1, 99, velCommand);
    waitc(100);
    cmpVal("vel", sx(16'd100), sx(velCommand));
    i_ctl.setSel(1'b0, 1'b1, 1'b1);
    waitc(150);
    cmpSpan("vel reversing", 1, 99, velCommand);
    waitc(250);
    cmpVal("vel", sx(-16'sd100), sx(velCommand));
    i_ctl.setSel(1'b0, 1'b0, 1'b0);
    waitc(250);
    cmpVal("vel", sx(16'd0), sx(velCommand));
    $display("test ramps done");
    apb(1'b1, CTRL_OFS, 32'h00000017);
    waitc(8);
    cmpVal("mode", MODE_IVEL, activeMode);
    for (int k = 0; k < 15; k++) begin
      i_ctl.setSw(1'b0);
      // Restart applies the pending method, so the code is written before it is applied
      apb(1'b1, CTRL_OFS, {22'h0, 1'b1, 5'h01, codes[k]});
      apb(1'b1, CTRL_OFS, {22'h0, 1'b1, 5'h01, codes[k]});
      waitc(8);
      cmpVal("first mode", m1[k], activeMode);
      i_ctl.setSw(1'b1);
      waitc(8);
      cmpVal("second mode", m2[k], activeMode);
    end
    $display("test dual codes done");
    apb(1'b1, RAMP_OFS, 32'h00010001);
    i_ctl.setSw(1'b0);
    apb(1'b1, CTRL_OFS, 32'h00000204);
    apb(1'b1, CTRL_OFS, 32'h00000204);
    posSettled <= 1'b1;
    waitc(8);
    cmpVal("mode", MODE_POS, activeMode);
    cmpVal("in position", 32'h1, {31'h0, inPositionOutput});
    p0 = pulseSeen;
    i_ctl.pulse(1'b0);
    waitc(6);
    cmpVal("pulses", p0 + 1, pulseSeen);
    i_ctl.setSel(1'b0, 1'b1, 1'b0);
    waitc(8);
    cmpVal("mode", MODE_IVEL, activeMode);
    cmpVal("in position", 32'h0, {31'h0, inPositionOutput});
    waitc(120);
    p0 = pulseSeen;
    i_ctl.pulse(1'b1);
    waitc(6);
    cmpVal("pulses", p0, pulseSeen);
    i_ctl.setSel(1'b0, 1'b0, 1'b0);
    waitc(20);
    cmpVal("mode", MODE_IVEL, activeMode);
    cmpSpan("vel stopping", 1, 99, velCommand);
    waitc(150);
    cmpVal("mode", MODE_POS, activeMode);
    cmpVal("vel", sx(16'd0), sx(velCommand));
    $display("test mode change done");
    wrap_up();
  end
endmodule // tb_top
